/* src/scw_params.svh */
// constants of the serial command, wake and status block
// assumes: included by its bare name from package and modules
`ifndef SCW_PARAMS_SVH
`define SCW_PARAMS_SVH

// command type codes, top three bits of the command byte
`define SCW_CMD_RD_BUF 3'h0
`define SCW_CMD_WR_BUF 3'h1
`define SCW_CMD_RD_REG 3'h2
`define SCW_CMD_WR_REG 3'h3
`define SCW_CMD_OFF 3'h4
`define SCW_CMD_CLR_IRQ 3'h5

// command byte fields
`define SCW_CMD_TYPE_MSB 7
`define SCW_CMD_TYPE_LSB 5
`define SCW_CMD_ADDR_MSB 4

// register address of the status register
`define SCW_ADDR_STATUS 5'h08

// status byte layout
`define SCW_STAT_WAKE 7
`define SCW_STAT_LOW 6
`define SCW_STAT_AUX 5

// width of the synchronised input group
`define SCW_SYNC_W 12

`endif

/* src/scw_pkg.sv */
// types of the serial command, wake and status block
// assumes: scw_params.svh on the include path
`include "scw_params.svh"

package scw_pkg;

    // where the interpreter stands within a frame
    typedef enum logic [1:0] {
        PH_CMD = 2'b00,
        PH_DATA = 2'b01,
        PH_IGNORE = 2'b10
    } scw_phase_t;

    // state of the byte shifter
    typedef struct packed {
        logic [2:0] cnt;
        logic [7:0] rx;
        logic [7:0] sh;
        logic sdo;
        logic rx_valid;
    } scw_shift_t;

    // state of the command interpreter
    typedef struct packed {
        logic sck_prev;
        logic wake_prev;
        logic aux_prev;
        scw_phase_t phase;
        logic [2:0] cmd;
        logic first;
        logic load_pend;
        logic [7:0] tx_byte;
        logic powered;
        logic wake_flag;
        logic aux_flag;
        logic low_flag;
        logic irq;
        logic sdo;
        logic sdo_oe;
        logic buf_rd;
        logic buf_wr;
        logic reg_rd;
        logic reg_wr;
        logic off_req;
        logic [4:0] reg_addr;
        logic [7:0] wr_data;
        logic ext_en;
        logic clk_en;
    } scw_core_t;

endpackage : scw_pkg

/* src/scw_shift_if.sv */
// bundle between the interpreter and its byte shifter
// assumes: both ends on the same clock
`timescale 1ns/1ps
`default_nettype none

interface scw_shift_if;
    logic frame;
    logic sck_rise;
    logic sck_fall;
    logic sdi;
    logic [7:0] tx_byte;
    logic [7:0] rx_byte;
    logic rx_valid;
    logic sdo;

    modport core (output frame, sck_rise, sck_fall, sdi, tx_byte,
        input rx_byte, rx_valid, sdo);
    modport shifter (input frame, sck_rise, sck_fall, sdi, tx_byte,
        output rx_byte, rx_valid, sdo);
endinterface : scw_shift_if

`default_nettype wire

/* src/scw_sync.sv */
// two-flop synchroniser for a group of pin inputs
// assumes: inputs asynchronous to clk, reset synchronous
`timescale 1ns/1ps
`default_nettype none

module scw_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } scw_sync_t;

    scw_sync_t s;
    scw_sync_t n;

    // refuse an empty group
    if (WIDTH < 1) begin : g_chk
        $error("scw_sync: WIDTH must be at least 1");
    end

    // first stage feeds only the second
    always_comb
    begin
        n = s;
        n.meta = d;
        n.stable = s.meta;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            s <= '0;
        end
        else
        begin
            s <= n;
        end
    end

    assign q = s.stable;
endmodule : scw_sync

`default_nettype wire

/* src/scw_shifter.sv */
// byte shifter: samples on rising, drives on falling serial clock
// assumes: edges found by the interpreter, frame low clears it
`timescale 1ns/1ps
`default_nettype none

module scw_shifter (
    input wire logic clk,
    input wire logic reset,
    scw_shift_if.shifter b
);
    scw_pkg::scw_shift_t s;
    scw_pkg::scw_shift_t n;

    // shift in, count bits, present next bit msb first
    always_comb
    begin
        n = s;
        n.rx_valid = 1'b0;
        if (!b.frame)
        begin
            n.cnt = 3'h0; // partial byte dropped
            n.sh = b.tx_byte;
            n.sdo = b.tx_byte[7];
        end
        else
        begin
            if (b.sck_rise)
            begin
                n.rx = {s.rx[6:0], b.sdi}; // msb first
                n.cnt = s.cnt + 3'h1;
                n.rx_valid = (s.cnt == 3'h7); // whole bytes
            end
            if (b.sck_fall)
            begin
                if (s.cnt == 3'h0)
                begin
                    n.sh = b.tx_byte;
                    n.sdo = b.tx_byte[7];
                end
                else
                begin
                    n.sh = {s.sh[6:0], 1'b0};
                    n.sdo = s.sh[6];
                end
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            s <= '0;
        end
        else
        begin
            s <= n;
        end
    end

    assign b.rx_byte = s.rx;
    assign b.rx_valid = s.rx_valid;
    assign b.sdo = s.sdo;

    // mid-byte falling edge puts out the next lower bit
    AST_SHIFT_ORDER: assert property (@(posedge clk) disable iff (reset)
        (b.frame && b.sck_fall && !b.sck_rise && s.cnt != 3'h0)
        |=> (s.sdo == $past(s.sh[6])))
        else $error("shifter bit order broken");
endmodule : scw_shifter

`default_nettype wire

/* src/scw_core.sv */
// serial command interpreter with wake, aux and low supply status
// assumes: buffer and register contents live outside; buffer head
// and register data are stable combinational answers to the pops
// and addresses driven here; runs only while the device is active
//
// How it works
// - each frame opens with one command byte; traffic is whole bytes
// - while the command shifts in, the buffer byte count shifts out
// - every byte travels most significant bit first
// - chip select low resets the serial logic and drops partial bytes
// - read and write commands carry one or more data bytes
// - top three bits pick the command, low five the register address
// - low five bits ignored outside register commands; host sends zero
// - codes: read buf, write buf, read reg, write reg, off, clear irq
// - buffer write echoes command then each data byte, one behind
// - register write echoes command and each written byte
// - register commands walk through successive addresses in a frame
// - off only with analog supply off, wake low and keys all high
// - clear-interrupt command drives the interrupt low
// - no serial traffic while host reset is low
// - select low and transparent off: output pin released
// - select low and transparent on: live receive stream out
// - wake pin rise sets wake flag; only its rise raises irq
// - aux rise with good voltage sets aux flag; rise raises irq
// - wake flag forces external supply and host clock enables on
// - low supply flag sets on low voltage, clears on read once recovered
// - after reset release the wake flag and interrupt are raised
// - wake pin low alone never requests off mode
// - status read clears wake and aux flags and interrupt, low supply flag only once recovered
`timescale 1ns/1ps
`default_nettype none
`include "scw_params.svh"

module scw_core (
    input wire logic clk,
    input wire logic reset,
    input wire logic chip_select,
    input wire logic serial_clock,
    input wire logic serial_in_pin,
    output logic serial_out_pin,
    output logic serial_out_oe,
    input wire logic transparent_select,
    input wire logic rx_stream,
    input wire logic host_reset_n,
    input wire logic [7:0] buffer_count,
    input wire logic [7:0] buf_rd_data,
    output logic buf_rd_pop,
    output logic buf_wr_push,
    output logic [7:0] write_data,
    output logic [4:0] reg_addr,
    input wire logic [7:0] reg_rd_data,
    output logic reg_rd_strobe,
    output logic reg_wr_strobe,
    input wire logic analog_supply_enable,
    input wire logic wake_pin,
    input wire logic aux_supply_pin,
    input wire logic aux_voltage_ok,
    input wire logic low_supply_cmp,
    input wire logic [4:0] key_inputs,
    input wire logic ctrl_ext_supply_en,
    input wire logic ctrl_host_clock_en,
    output logic ext_supply_enable,
    output logic host_clock_enable,
    output logic wake_flag,
    output logic aux_power_flag,
    output logic low_supply_flag,
    output logic irq_out,
    output logic off_mode_req
);
    scw_pkg::scw_core_t s;
    scw_pkg::scw_core_t n;
    logic [`SCW_SYNC_W-1:0] raw;
    logic [`SCW_SYNC_W-1:0] syn;
    logic cs_s;
    logic sck_s;
    logic sdi_s;
    logic wake_s;
    logic aux_s;
    logic aux_ok_s;
    logic low_s;
    logic [4:0] keys_s;
    logic wake_edge;
    logic aux_edge;
    logic status_read;
    logic clr_cmd;
    logic [2:0] rx_cmd;
    logic [7:0] status_byte;

    scw_shift_if b ();

    // select, serial, wake, aux, low supply and key inputs pass two flops first
    assign raw = {chip_select, serial_clock, serial_in_pin, wake_pin,
        aux_supply_pin, aux_voltage_ok, low_supply_cmp, key_inputs};

    scw_sync #(
        .WIDTH(`SCW_SYNC_W)
    ) u_sync (
        .clk(clk),
        .reset(reset),
        .d(raw),
        .q(syn)
    );

    assign {cs_s, sck_s, sdi_s, wake_s, aux_s, aux_ok_s, low_s,
        keys_s} = syn;

    // frame and clock edges handed to the shifter
    assign b.frame = cs_s && host_reset_n;
    assign b.sck_rise = sck_s && !s.sck_prev;
    assign b.sck_fall = !sck_s && s.sck_prev;
    assign b.sdi = sdi_s;
    assign b.tx_byte = s.tx_byte;

    scw_shifter u_shifter (
        .clk(clk),
        .reset(reset),
        .b(b.shifter)
    );

    // event detection and the status byte
    assign wake_edge = wake_s && !s.wake_prev;
    assign aux_edge = aux_s && !s.aux_prev && aux_ok_s;
    assign rx_cmd = b.rx_byte[`SCW_CMD_TYPE_MSB:`SCW_CMD_TYPE_LSB];
    assign status_byte = {s.wake_flag, s.low_flag, s.aux_flag,
        ~keys_s};

    // command decode, data phases, flags and pin drive
    always_comb
    begin
        n = s;
        status_read = 1'b0;
        clr_cmd = 1'b0;
        n.sck_prev = sck_s;
        n.wake_prev = wake_s;
        n.aux_prev = aux_s;
        n.buf_rd = 1'b0;
        n.buf_wr = 1'b0;
        n.reg_rd = 1'b0;
        n.reg_wr = 1'b0;
        n.off_req = 1'b0;
        n.load_pend = 1'b0;
        n.powered = 1'b1;
        if (!b.frame)
        begin
            n.phase = scw_pkg::PH_CMD;
            n.tx_byte = buffer_count;
        end
        else if (b.rx_valid)
        begin
            unique case (s.phase)
                scw_pkg::PH_CMD:
                begin
                    n.cmd = rx_cmd;
                    n.first = 1'b1;
                    n.tx_byte = b.rx_byte;
                    n.phase = scw_pkg::PH_DATA;
                    // low five bits only matter for registers
                    if (rx_cmd == `SCW_CMD_RD_REG ||
                        rx_cmd == `SCW_CMD_WR_REG)
                    begin
                        n.reg_addr = b.rx_byte[`SCW_CMD_ADDR_MSB:0];
                    end
                    unique case (rx_cmd)
                        `SCW_CMD_RD_BUF, `SCW_CMD_RD_REG:
                        begin
                            n.load_pend = 1'b1;
                        end
                        `SCW_CMD_WR_BUF, `SCW_CMD_WR_REG:
                        begin
                        end
                        `SCW_CMD_OFF:
                        begin
                            n.phase = scw_pkg::PH_IGNORE;
                            n.off_req = !analog_supply_enable &&
                                !wake_s && (&keys_s);
                        end
                        `SCW_CMD_CLR_IRQ:
                        begin
                            n.phase = scw_pkg::PH_IGNORE;
                            clr_cmd = 1'b1;
                        end
                        default:
                        begin
                            n.phase = scw_pkg::PH_IGNORE;
                        end
                    endcase
                end
                scw_pkg::PH_DATA:
                begin
                    n.first = 1'b0;
                    unique case (s.cmd)
                        `SCW_CMD_WR_BUF:
                        begin
                            n.buf_wr = 1'b1;
                            n.wr_data = b.rx_byte;
                            n.tx_byte = b.rx_byte;
                        end
                        `SCW_CMD_WR_REG:
                        begin
                            n.reg_wr = 1'b1;
                            n.wr_data = b.rx_byte;
                            n.tx_byte = b.rx_byte;
                            if (!s.first)
                            begin
                                n.reg_addr = s.reg_addr + 5'h01;
                            end
                        end
                        `SCW_CMD_RD_REG:
                        begin
                            n.reg_addr = s.reg_addr + 5'h01;
                            n.load_pend = 1'b1;
                        end
                        default:
                        begin
                            n.load_pend = 1'b1;
                        end
                    endcase
                end
                scw_pkg::PH_IGNORE:
                begin
                end
            endcase
        end
        // fetch the next outgoing byte a cycle after the request
        if (s.load_pend && b.frame)
        begin
            if (s.cmd == `SCW_CMD_RD_BUF)
            begin
                n.buf_rd = 1'b1;
                n.tx_byte = buf_rd_data;
            end
            else
            begin
                n.reg_rd = 1'b1;
                status_read = (s.reg_addr == `SCW_ADDR_STATUS);
                n.tx_byte = status_read ? status_byte : reg_rd_data;
            end
        end
        // clears first, so that a same-cycle event still sets
        if (status_read)
        begin
            n.wake_flag = 1'b0;
            n.aux_flag = 1'b0;
            n.irq = 1'b0;
            n.low_flag = low_s;
        end
        if (clr_cmd)
        begin
            n.irq = 1'b0;
        end
        if (wake_edge || !s.powered)
        begin
            n.wake_flag = 1'b1;
            n.irq = n.irq || !s.wake_flag || status_read;
        end
        if (aux_edge)
        begin
            n.aux_flag = 1'b1;
            n.irq = n.irq || !s.aux_flag || status_read;
        end
        if (low_s)
        begin
            n.low_flag = 1'b1;
        end
        n.ext_en = ctrl_ext_supply_en || n.wake_flag;
        n.clk_en = ctrl_host_clock_en || n.wake_flag;
        // output pin: shifter, transparent stream or released
        if (b.frame)
        begin
            n.sdo = b.sdo;
            n.sdo_oe = 1'b1;
        end
        else
        begin
            n.sdo = transparent_select && rx_stream;
            n.sdo_oe = transparent_select;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            s <= '0;
        end
        else
        begin
            s <= n;
        end
    end

    assign serial_out_pin = s.sdo;
    assign serial_out_oe = s.sdo_oe;
    assign buf_rd_pop = s.buf_rd;
    assign buf_wr_push = s.buf_wr;
    assign write_data = s.wr_data;
    assign reg_addr = s.reg_addr;
    assign reg_rd_strobe = s.reg_rd;
    assign reg_wr_strobe = s.reg_wr;
    assign ext_supply_enable = s.ext_en;
    assign host_clock_enable = s.clk_en;
    assign wake_flag = s.wake_flag;
    assign aux_power_flag = s.aux_flag;
    assign low_supply_flag = s.low_flag;
    assign irq_out = s.irq;
    assign off_mode_req = s.off_req;

    // checks on the interpreter
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    AST_CS_LOW_RELEASE: assert property (
        (!cs_s && !transparent_select) |=> !serial_out_oe)
        else $error("output not released with select low");

    AST_TRANSPARENT: assert property (
        (!cs_s && transparent_select) |=>
        (serial_out_oe && serial_out_pin == $past(rx_stream)))
        else $error("receive stream not passed through");

    AST_WAKE_FORCE: assert property (
        wake_flag |-> (ext_supply_enable && host_clock_enable))
        else $error("wake flag does not force enables");

    AST_IRQ_CAUSE: assert property (
        $rose(irq_out) |-> ($rose(wake_flag) || $rose(aux_power_flag) ||
        $past(status_read)))
        else $error("interrupt raised without flag rise");

    AST_CLR_IRQ: assert property (
        (clr_cmd && !wake_edge && !aux_edge && s.powered) |=> !irq_out)
        else $error("clear command left interrupt high");

    AST_OFF_GUARD: assert property (
        off_mode_req |-> (!$past(analog_supply_enable) && !$past(wake_s)
        && (&$past(keys_s)) && $past(s.phase) == scw_pkg::PH_CMD))
        else $error("off requested without its conditions");

    AST_FRAME_RESET: assert property (
        !b.frame |=> (s.phase == scw_pkg::PH_CMD &&
        s.tx_byte == $past(buffer_count)))
        else $error("serial logic not reset outside frame");

    AST_STATUS_CLEAR: assert property (
        (status_read && !wake_edge && !aux_edge) |=>
        (!wake_flag && !aux_power_flag && !irq_out))
        else $error("status read did not clear flags");

    AST_POWERUP: assert property (
        !s.powered |=> (wake_flag && irq_out) [*2])
        else $error("wake flag not raised after reset");

    AST_LOW_HOLD: assert property (
        (low_supply_flag && !status_read) |=> low_supply_flag)
        else $error("low supply flag dropped without read");
endmodule : scw_core

`default_nettype wire

/* tb/scw_host_model.sv */
// host serial master model that drives the command link
// assumes: tasks are called from the bench at the falling clk edge
`timescale 1ns/1ps
`default_nettype none

module scw_host_model (
    input wire logic host_reset_n,
    input wire logic sdo,
    output logic cs,
    output logic sck,
    output logic sdi
);
    // link at rest: select low, serial clock low
    initial
    begin
        cs = 1'b0;
        sck = 1'b0;
        sdi = 1'b0;
    end

    // open a frame only while the device is out of reset
    task automatic sel_on();
        wait (host_reset_n === 1'b1);
        cs = 1'b1;
        #300;
    endtask : sel_on

    // one whole byte, msb first; bits change low, read before the fall
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--)
        begin
            sck = 1'b0;
            sdi = tx[i];
            #100;
            sck = 1'b1;
            #100;
            rx[i] = sdo;
        end
    endtask : xfer

    // close the frame; released data line no longer shows the last bit
    task automatic sel_off();
        #100;
        cs = 1'b0;
        #100;
        sck = 1'b0;
        sdi = ~sdi;
        #200;
    endtask : sel_off
endmodule : scw_host_model

`default_nettype wire

/* tb/scw_core_tb.sv */
// self-checking bench for the serial command and status block
// assumes: host model drives the link, bench drives the rest
`timescale 1ns/1ps
`default_nettype none

module scw_core_tb;
    logic clk, reset, chip_select, serial_clock, serial_in_pin;
    logic serial_out_pin, serial_out_oe, transparent_select, rx_stream;
    logic host_reset_n, buf_rd_pop, buf_wr_push, reg_rd_strobe;
    logic reg_wr_strobe, analog_supply_enable, wake_pin, aux_supply_pin;
    logic aux_voltage_ok, low_supply_cmp, ext_supply_enable;
    logic host_clock_enable, wake_flag, aux_power_flag, low_supply_flag;
    logic irq_out, off_mode_req, ctrl_ext_supply_en, ctrl_host_clock_en;
    logic [7:0] buffer_count, buf_rd_data, write_data, reg_rd_data, rx;
    logic [4:0] reg_addr, key_inputs;
    logic [12:0] wr_q[$];
    logic [7:0] push_q[$];
    int n_fail, n_tests, n_pop, n_off, n_rrd, cyc;
    wire sdo_w;

    // pin as the host sees it: floats while the device lets go
    assign sdo_w = serial_out_oe ? serial_out_pin : 1'bz;
    assign reg_rd_data = {3'h0, reg_addr};

    scw_core u_dut (.clk(clk), .reset(reset), .chip_select(chip_select),
        .serial_clock(serial_clock), .serial_in_pin(serial_in_pin),
        .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe),
        .transparent_select(transparent_select), .rx_stream(rx_stream),
        .host_reset_n(host_reset_n), .buffer_count(buffer_count),
        .buf_rd_data(buf_rd_data), .buf_rd_pop(buf_rd_pop),
        .buf_wr_push(buf_wr_push), .write_data(write_data),
        .reg_addr(reg_addr), .reg_rd_data(reg_rd_data),
        .reg_rd_strobe(reg_rd_strobe), .reg_wr_strobe(reg_wr_strobe),
        .analog_supply_enable(analog_supply_enable), .wake_pin(wake_pin),
        .aux_supply_pin(aux_supply_pin), .aux_voltage_ok(aux_voltage_ok),
        .low_supply_cmp(low_supply_cmp), .key_inputs(key_inputs),
        .ctrl_ext_supply_en(ctrl_ext_supply_en),
        .ctrl_host_clock_en(ctrl_host_clock_en),
        .ext_supply_enable(ext_supply_enable),
        .host_clock_enable(host_clock_enable), .wake_flag(wake_flag),
        .aux_power_flag(aux_power_flag), .low_supply_flag(low_supply_flag),
        .irq_out(irq_out), .off_mode_req(off_mode_req));

    scw_host_model u_host (.host_reset_n(host_reset_n), .sdo(sdo_w),
        .cs(chip_select), .sck(serial_clock), .sdi(serial_in_pin));

    // clock, 25 ns period
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // log strobes where they stand, count cycles and cut a hang short
    always @(negedge clk)
    begin
        cyc++;
        if (reg_wr_strobe === 1'b1) wr_q.push_back({reg_addr, write_data});
        if (reg_rd_strobe === 1'b1) n_rrd++;
        if (buf_wr_push === 1'b1) push_q.push_back(write_data);
        if (buf_rd_pop === 1'b1) n_pop++;
        if (off_mode_req === 1'b1) n_off++;
        if (cyc == 40000)
        begin
            n_fail++;
            summarize();
        end
    end

    // buffer head moves on after each pop
    always @(negedge clk)
        if (buf_rd_pop === 1'b1) buf_rd_data <= ~buf_rd_data;

    task automatic chk(input string nm, input logic [7:0] e, logic [7:0] g);
        n_tests++;
        if (g !== e)
        begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask : wt

    function automatic logic [7:0] flg();
        return {4'h0, wake_flag, aux_power_flag, low_supply_flag, irq_out};
    endfunction : flg

    function automatic logic [7:0] ens();
        return {6'h0, ext_supply_enable, host_clock_enable};
    endfunction : ens

    // frame of a command byte followed by one dummy byte
    task automatic frame2(input logic [7:0] c);
        u_host.sel_on();
        u_host.xfer(c, rx);
        u_host.xfer(8'h00, rx);
        u_host.sel_off();
    endtask : frame2

    task automatic t_status();
        chk("wake at start", 8'h09, flg());
        chk("enables", 8'h03, ens());
        low_supply_cmp = 1'b1;
        wt(8);
        chk("low set", 8'h0B, flg());
        u_host.sel_on();
        u_host.xfer(8'h48, rx);
        chk("count", 8'h05, rx);
        u_host.xfer(8'h00, rx);
        u_host.sel_off();
        chk("status", 8'hC0, rx);
        chk("after read", 8'h02, flg());
        chk("enables off", 8'h00, ens());
        {ctrl_ext_supply_en, ctrl_host_clock_en} = 2'h2;
        wt(2);
        chk("ctrl ext", 8'h02, ens());
        {ctrl_ext_supply_en, ctrl_host_clock_en} = 2'h1;
        wt(2);
        chk("ctrl clk", 8'h01, ens());
        {ctrl_ext_supply_en, ctrl_host_clock_en} = 2'h0;
        low_supply_cmp = 1'b0;
        wt(8);
        // status, then the next register in the same frame
        u_host.sel_on();
        u_host.xfer(8'h48, rx);
        u_host.xfer(8'h00, rx);
        chk("status2", 8'h40, rx);
        u_host.xfer(8'h00, rx);
        u_host.sel_off();
        chk("next reg", 8'h09, rx);
        chk("reg reads", 8'h05, 8'(n_rrd));
        chk("low clear", 8'h00, flg());
    endtask : t_status

    task automatic t_regwr();
        u_host.sel_on();
        u_host.xfer(8'h63, rx);
        u_host.xfer(8'h5A, rx);
        chk("echo cmd", 8'h63, rx);
        u_host.xfer(8'hA5, rx);
        chk("echo data", 8'h5A, rx);
        u_host.sel_off();
        chk("writes", 8'h02, 8'(wr_q.size()));
        chk("addr0", 8'h03, 8'(wr_q[0][12:8]));
        chk("data0", 8'h5A, wr_q[0][7:0]);
        chk("addr1", 8'h04, 8'(wr_q[1][12:8]));
        chk("data1", 8'hA5, wr_q[1][7:0]);
    endtask : t_regwr

    // host reset inside a frame drops the command taken so far
    task automatic t_hrst();
        u_host.sel_on();
        u_host.xfer(8'h63, rx);
        host_reset_n = 1'b0;
        wt(4);
        host_reset_n = 1'b1;
        wt(4);
        u_host.xfer(8'hC0, rx);
        u_host.sel_off();
        chk("no write", 8'h02, 8'(wr_q.size()));
    endtask : t_hrst

    task automatic t_buf();
        u_host.sel_on();
        u_host.xfer(8'h20, rx);
        u_host.xfer(8'h11, rx);
        chk("buf echo cmd", 8'h20, rx);
        u_host.xfer(8'h22, rx);
        chk("buf echo data", 8'h11, rx);
        u_host.sel_off();
        chk("pushes", 8'h02, 8'(push_q.size()));
        chk("push last", 8'h22, push_q[1]);
        u_host.sel_on();
        u_host.xfer(8'h00, rx);
        u_host.xfer(8'h00, rx);
        chk("head0", 8'hC3, rx);
        u_host.xfer(8'h00, rx);
        u_host.sel_off();
        chk("head1", 8'h3C, rx);
        // pop at load: the byte fetched after the last one read goes too
        chk("pops", 8'h03, 8'(n_pop));
    endtask : t_buf

    task automatic t_irq();
        aux_voltage_ok = 1'b1;
        aux_supply_pin = 1'b1;
        wt(8);
        chk("aux rise", 8'h05, flg());
        frame2(8'hA0);
        chk("clear irq", 8'h04, flg());
        wake_pin = 1'b1;
        wt(8);
        chk("wake rise", 8'h0D, flg());
        chk("wake enables", 8'h03, ens());
        frame2(8'hBF);
        wake_pin = 1'b0;
        wt(8);
        wake_pin = 1'b1;
        wt(8);
        chk("no second irq", 8'h0C, flg());
    endtask : t_irq

    task automatic t_off();
        int base;
        frame2(8'h80);
        chk("off wake high", 8'h00, 8'(n_off));
        wake_pin = 1'b0;
        wt(20);
        chk("wake low only", 8'h00, 8'(n_off));
        frame2(8'h9F);
        chk("off taken", 8'h01, 8'(n_off));
        analog_supply_enable = 1'b1;
        frame2(8'h80);
        chk("off analog on", 8'h01, 8'(n_off));
        analog_supply_enable = 1'b0;
        key_inputs = 5'h1E;
        frame2(8'h80);
        chk("off key down", 8'h01, 8'(n_off));
        key_inputs = 5'h1F;
        // unused codes must leave every strobe count where it was
        base = n_off + n_pop + n_rrd + wr_q.size() + push_q.size();
        frame2(8'hC0);
        frame2(8'hE0);
        chk("unused", 8'(base),
            8'(n_off + n_pop + n_rrd + wr_q.size() + push_q.size()));
    endtask : t_off

    task automatic t_transp();
        transparent_select = 1'b1;
        rx_stream = 1'b1;
        wt(4);
        chk("transp hi", 8'h03, {6'h0, serial_out_oe, serial_out_pin});
        rx_stream = 1'b0;
        wt(3);
        chk("transp lo", 8'h02, {6'h0, serial_out_oe, serial_out_pin});
        transparent_select = 1'b0;
        wt(4);
        chk("released", 8'h00, {7'h0, serial_out_oe});
    endtask : t_transp

    task automatic summarize();
        $display("tests %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : summarize

    // reset, then each scenario in turn
    initial
    begin
        {n_fail, n_tests, n_pop, n_off, n_rrd, cyc} = '0;
        reset = 1'b1;
        {transparent_select, rx_stream, analog_supply_enable} = 3'h0;
        {ctrl_ext_supply_en, ctrl_host_clock_en} = 2'h0;
        {wake_pin, aux_supply_pin, aux_voltage_ok, low_supply_cmp} = 4'h0;
        host_reset_n = 1'b1;
        buffer_count = 8'h05;
        buf_rd_data = 8'hC3;
        key_inputs = 5'h1F;
        repeat (4) @(negedge clk);
        reset = 1'b0;
        wt(6);
        t_status();
        t_regwr();
        t_hrst();
        t_buf();
        t_irq();
        t_off();
        t_transp();
        summarize();
    end
endmodule : scw_core_tb

`default_nettype wire
